// ---- core/rtc_pkg.sv ----
// shared constants of the calendar counter block: map, fields, limits
// assumes a 10 MHz system clock and a plain strobe register port
package rtc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int PRESC_HZ = 256;
  localparam int SW_HZ = 100;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_SEC = 4'h2;
  localparam logic [3:0] A_HOUR = 4'h4;
  localparam logic [3:0] A_MONTH = 4'h6;
  localparam logic [3:0] A_YEAR = 4'h8;
  localparam logic [3:0] A_FLAG = 4'ha;
  localparam logic [3:0] A_ENABLE = 4'hc;
  localparam logic [3:0] A_SW = 4'he;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int HI_LSB = 8;
  localparam int LO_LSB = 0;
  localparam int PM_BIT = 14;
  localparam int CTL_CLR_BIT = 1;
  localparam int CTL_24H_BIT = 4;
  localparam int CTL_BUSY_BIT = 6;
  localparam int SW_GO_BIT = 0;
  localparam int SW_ZERO_BIT = 4;
  localparam int F_TRIM = 15;
  localparam int F_SW1 = 14;
  localparam int F_SW10 = 13;
  localparam int F_SW100 = 12;
  localparam int F_ALARM = 8;
  localparam int F_DAY = 7;
  localparam int F_HOUR = 6;
  localparam int F_MIN = 5;
  localparam int F_SEC = 4;
  localparam int F_HALF = 3;
  localparam int F_QUARTER = 2;
  localparam int F_EIGHTH = 1;
  localparam int F_T32 = 0;
  localparam int TAP_HALF = 6;
  localparam int TAP_QUARTER = 5;
  localparam int TAP_EIGHTH = 4;
  localparam int TAP_T32 = 2;
  localparam logic [15:0] FLAG_MASK = 16'hf1ff;
  // ----------------------------------------
  // reset values and count limits (bcd except the binary PRESC_TOP)
  // ----------------------------------------
  localparam logic [5:0] HOUR_RST = 6'h12;
  localparam logic [4:0] MONTH_RST = 5'h01;
  localparam logic [5:0] DAY_RST = 6'h01;
  localparam logic [6:0] SEC_MAX = 7'h59;
  localparam logic [6:0] MIN_MAX = 7'h59;
  localparam logic [5:0] HOUR24_MAX = 6'h23;
  localparam logic [5:0] HOUR12_MAX = 6'h12;
  localparam logic [5:0] HOUR12_PRE = 6'h11;
  localparam logic [5:0] HOUR12_MIN = 6'h01;
  localparam logic [4:0] MONTH_MAX = 5'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [2:0] WEEK_MAX = 3'h6;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [7:0] PRESC_TOP = 8'hff;
endpackage

// ---- core/tick_divider.sv ----
// divides the system clock into a one-cycle tick every DIV cycles
// assumes DIV of at least 2 and a synchronous active-high reset
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV = 2
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  output logic tick // one-cycle pulse
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == LAST);
    end
  end
endmodule

// ---- core/w1c_flag.sv ----
// one sticky cause flag, cleared by a write of one
// assumes set and clear are single-cycle terms on the same clock
`timescale 1ns/10ps
module w1c_flag (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic set, // event
  input wire logic clr, // software clear
  output logic flag // sticky state
);
  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end
endmodule

// ---- core/rtc_calendar_counters.sv ----
// calendar, time-of-day and stopwatch counters with cause flags
// assumes one 10 MHz clock, synchronous reset, and a strobe register port
// whose read data appear in the cycle after the read strobe
`timescale 1ns/10ps

// Contract
// - stopwatch holds count while stopped, resumes
// - stopwatch stops at next stopwatch tick
// - seconds bcd 0..59 in bits 14..8
// - prescaler taps readable, bit7 is 1 Hz
// - prescaler clear bit zeroes all taps
// - pm flag bit 14 in 12-hour mode
// - pm reads zero, ignores one in 24h
// - stale pm cleared at next hour count
// - hours bcd 1..12 or 0..23
// - minutes bcd 0..59 in bits 6..0
// - month bcd 1..12 in bits 12..8
// - day wraps per month length, leap years
// - weekday counts 0..6 modulo seven
// - year bcd 0..99 in bits 7..0
// - cause flags set by events, write-one clears
// - busy high 1/256 s per second count
// - flag bit assignment of all causes
// - enabled set flag raises interrupt request
// - hour format select, stored hour untouched
module rtc_calendar_counters
  import rtc_pkg::*;
#(
  parameter int PRESC_DIV = CLK_HZ / PRESC_HZ,
  parameter int SW_DIV = CLK_HZ / SW_HZ
) (
  input wire logic MCLK, // system clock
  input wire logic SRST, // synchronous reset, active high
  input wire logic [3:0] ADDR, // register byte address
  input wire logic [15:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic ALARM_EVENT, // alarm match pulse
  input wire logic TRIM_EVENT, // trimming done pulse
  output logic [15:0] RDATA, // read data
  output logic IRQ // interrupt request
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] presc_reg;
  logic [6:0] sec_reg;
  logic [6:0] min_reg;
  logic [5:0] hour_reg;
  logic pm_reg;
  logic [5:0] day_reg;
  logic [4:0] month_reg;
  logic [2:0] week_reg;
  logic [7:0] year_reg;
  logic hour_format_sel;
  logic count_busy;
  logic stopwatch_go;
  logic sw_run_reg;
  logic [7:0] sw_count_reg;
  logic [15:0] enable_reg;
  logic [15:0] flag_q;
  logic [15:0] flag_set;
  logic tick256;
  logic sw_tick;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_ctrl, wr_sec, wr_hour, wr_month, wr_year, wr_flag, wr_enable, wr_sw;
  assign wr_ctrl = WR && ADDR == A_CTRL;
  assign wr_sec = WR && ADDR == A_SEC;
  assign wr_hour = WR && ADDR == A_HOUR;
  assign wr_month = WR && ADDR == A_MONTH;
  assign wr_year = WR && ADDR == A_YEAR;
  assign wr_flag = WR && ADDR == A_FLAG;
  assign wr_enable = WR && ADDR == A_ENABLE;
  assign wr_sw = WR && ADDR == A_SW;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == DIGIT_MAX) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  tick_divider #(.DIV(PRESC_DIV)) u_presc_div (
    .clk(MCLK),
    .rst(SRST),
    .tick(tick256)
  );

  logic presc_clear;
  logic presc_step;
  logic [7:0] presc_fall;
  assign presc_clear = wr_ctrl && WDATA[CTL_CLR_BIT];
  assign presc_step = tick256 && !presc_clear;
  // taps that drop from one to zero on this step mark their period
  assign presc_fall = presc_reg & ~(presc_reg + 8'h01);

  always_ff @(posedge MCLK) begin
    if (SRST || presc_clear) begin
      presc_reg <= 8'h00;
    end else if (tick256) begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  logic sec_tick;
  assign sec_tick = presc_step && presc_reg == PRESC_TOP;

  // busy spans exactly one prescaler step after the second count
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      count_busy <= 1'b0;
    end else if (sec_tick) begin
      count_busy <= 1'b1;
    end else if (tick256) begin
      count_busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // carry chain
  // ----------------------------------------
  logic sec_wrap, min_up, min_wrap, hour_up, day_up, month_up, year_up;
  logic [5:0] hour_next;
  logic pm_next;
  logic hour_wrap;
  logic [7:0] hour_inc;
  logic [5:0] day_max;
  logic leap;
  logic [3:0] leap_sum;

  assign sec_wrap = sec_tick && sec_reg == SEC_MAX;
  assign min_up = sec_wrap;
  assign min_wrap = min_up && min_reg == MIN_MAX;
  assign hour_up = min_wrap;
  assign day_up = hour_up && hour_wrap;
  assign month_up = day_up && day_reg == day_max;
  assign year_up = month_up && month_reg == MONTH_MAX;
  assign hour_inc = bcd_inc({2'h0, hour_reg});

  always_comb begin
    hour_next = hour_inc[5:0];
    pm_next = pm_reg;
    hour_wrap = 1'b0;
    if (hour_format_sel) begin
      pm_next = 1'b0;
      if (hour_reg == HOUR24_MAX) begin
        hour_next = 6'h00;
        hour_wrap = 1'b1;
      end
    end else if (hour_reg == HOUR12_MAX) begin
      hour_next = HOUR12_MIN;
    end else if (hour_reg == HOUR12_PRE) begin
      pm_next = ~pm_reg;
      hour_wrap = pm_reg;
    end
  end

  // leap when (2*tens + units) of the bcd year is a multiple of four
  assign leap_sum = year_reg[3:0] + {2'h0, year_reg[4], 1'b0};
  assign leap = leap_sum[1:0] == 2'h0;

  always_comb begin
    case (month_reg)
      5'h02: day_max = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: day_max = 6'h30;
      default: day_max = 6'h31;
    endcase
  end

  // ----------------------------------------
  // time of day
  // ----------------------------------------
  logic [7:0] sec_inc, min_inc;
  assign sec_inc = bcd_inc({1'b0, sec_reg});
  assign min_inc = bcd_inc({1'b0, min_reg});

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sec_reg <= 7'h00;
    end else if (wr_sec) begin
      sec_reg <= WDATA[HI_LSB +: 7];
    end else if (sec_tick) begin
      sec_reg <= sec_wrap ? 7'h00 : sec_inc[6:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      min_reg <= 7'h00;
    end else if (wr_hour) begin
      min_reg <= WDATA[LO_LSB +: 7];
    end else if (min_up) begin
      min_reg <= min_wrap ? 7'h00 : min_inc[6:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      hour_reg <= HOUR_RST;
    end else if (wr_hour) begin
      hour_reg <= WDATA[HI_LSB +: 6];
    end else if (hour_up) begin
      hour_reg <= hour_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pm_reg <= 1'b0;
    end else if (wr_hour) begin
      pm_reg <= WDATA[PM_BIT] & ~hour_format_sel;
    end else if (hour_up) begin
      pm_reg <= pm_next;
    end
  end

  // ----------------------------------------
  // calendar
  // ----------------------------------------
  logic [7:0] day_inc, month_inc, year_inc;
  assign day_inc = bcd_inc({2'h0, day_reg});
  assign month_inc = bcd_inc({3'h0, month_reg});
  assign year_inc = bcd_inc(year_reg);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      day_reg <= DAY_RST;
    end else if (wr_month) begin
      day_reg <= WDATA[LO_LSB +: 6];
    end else if (day_up) begin
      day_reg <= month_up ? DAY_RST : day_inc[5:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      month_reg <= MONTH_RST;
    end else if (wr_month) begin
      month_reg <= WDATA[HI_LSB +: 5];
    end else if (month_up) begin
      month_reg <= year_up ? MONTH_RST : month_inc[4:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      week_reg <= 3'h0;
    end else if (wr_year) begin
      week_reg <= WDATA[HI_LSB +: 3];
    end else if (day_up) begin
      week_reg <= (week_reg >= WEEK_MAX) ? 3'h0 : week_reg + 3'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      year_reg <= 8'h00;
    end else if (wr_year) begin
      year_reg <= WDATA[LO_LSB +: 8];
    end else if (year_up) begin
      year_reg <= (year_reg == YEAR_MAX) ? 8'h00 : year_inc;
    end
  end

  // ----------------------------------------
  // control
  // ----------------------------------------
  // format change leaves the stored hour alone; software rewrites it
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      hour_format_sel <= 1'b0;
    end else if (wr_ctrl) begin
      hour_format_sel <= WDATA[CTL_24H_BIT];
    end
  end

  // ----------------------------------------
  // stopwatch
  // ----------------------------------------
  tick_divider #(.DIV(SW_DIV)) u_sw_div (
    .clk(MCLK),
    .rst(SRST),
    .tick(sw_tick)
  );

  logic sw_zero;
  logic sw_carry10, sw_carry1;
  assign sw_zero = wr_sw && WDATA[SW_ZERO_BIT];
  assign sw_carry10 = sw_tick && sw_run_reg && sw_count_reg[3:0] == DIGIT_MAX;
  assign sw_carry1 = sw_carry10 && sw_count_reg[7:4] == DIGIT_MAX;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      stopwatch_go <= 1'b0;
    end else if (wr_sw) begin
      stopwatch_go <= WDATA[SW_GO_BIT];
    end
  end

  // the go bit is only sampled on a stopwatch tick, so one more
  // count can land after software clears it
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sw_run_reg <= 1'b0;
    end else if (sw_tick) begin
      sw_run_reg <= stopwatch_go;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST || sw_zero) begin
      sw_count_reg <= 8'h00;
    end else if (sw_tick && sw_run_reg) begin
      sw_count_reg <= sw_carry1 ? 8'h00 : bcd_inc(sw_count_reg);
    end
  end

  // ----------------------------------------
  // cause flags and request
  // ----------------------------------------
  always_comb begin
    flag_set = 16'h0000;
    flag_set[F_TRIM] = TRIM_EVENT;
    flag_set[F_SW1] = sw_carry1;
    flag_set[F_SW10] = sw_carry10;
    flag_set[F_SW100] = sw_tick && sw_run_reg;
    flag_set[F_ALARM] = ALARM_EVENT;
    flag_set[F_DAY] = day_up;
    flag_set[F_HOUR] = hour_up;
    flag_set[F_MIN] = min_up;
    flag_set[F_SEC] = sec_tick;
    flag_set[F_HALF] = presc_step && presc_fall[TAP_HALF];
    flag_set[F_QUARTER] = presc_step && presc_fall[TAP_QUARTER];
    flag_set[F_EIGHTH] = presc_step && presc_fall[TAP_EIGHTH];
    flag_set[F_T32] = presc_step && presc_fall[TAP_T32];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (FLAG_MASK[gi]) begin : g_on
        w1c_flag u_flag (
          .clk(MCLK),
          .rst(SRST),
          .set(flag_set[gi]),
          .clr(wr_flag && WDATA[gi]),
          .flag(flag_q[gi])
        );
      end else begin : g_off
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      enable_reg <= 16'h0000;
    end else if (wr_enable) begin
      enable_reg <= WDATA & FLAG_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flag_q & enable_reg);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (ADDR)
      A_CTRL: begin
        rd_mux[CTL_24H_BIT] = hour_format_sel;
        rd_mux[CTL_BUSY_BIT] = count_busy;
      end
      A_SEC: rd_mux = {1'b0, sec_reg, presc_reg};
      A_HOUR: rd_mux = {1'b0, pm_reg & ~hour_format_sel, hour_reg, 1'b0, min_reg};
      A_MONTH: rd_mux = {3'h0, month_reg, 2'h0, day_reg};
      A_YEAR: rd_mux = {5'h00, week_reg, year_reg};
      A_FLAG: rd_mux = flag_q;
      A_ENABLE: rd_mux = enable_reg;
      A_SW: rd_mux = {sw_count_reg, 7'h00, stopwatch_go};
      default: rd_mux = 16'h0000;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge MCLK) begin
    if (SRST || !RD) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= rd_mux;
    end
  end
endmodule

// ---- verification/rtc_calendar_counters_chk.sv ----
// port-level checker of the calendar counter block
// assumes the block is reached only through its strobe register port
`timescale 1ns/10ps
module rtc_calendar_counters_chk
  import rtc_pkg::*;
(
  input wire logic MCLK, // clock
  input wire logic SRST, // reset
  input wire logic [3:0] ADDR, // address
  input wire logic [15:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic ALARM_EVENT, // alarm pulse
  input wire logic TRIM_EVENT, // trim pulse
  input wire logic [15:0] RDATA, // read data
  input wire logic IRQ // request
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  logic fmt24_reg;
  // ----
  // mode shadow
  // ----
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fmt24_reg <= 1'b0;
    end else if (WR && ADDR == A_CTRL) begin
      fmt24_reg <= WDATA[CTL_24H_BIT];
    end
  end
  sequence rd_of(logic [3:0] ad);
    RD && ADDR == ad;
  endsequence
  // ----
  // assertions
  // ----
  a_flag_gap_zero: assert property (rd_of(A_FLAG) |=> RDATA[11:9] == 3'h0)
    else $error("flag gap bits not zero");
  a_sec_bcd_range: assert property (rd_of(A_SEC) |=>
    !RDATA[15] && RDATA[14:12] <= 3'h5 && RDATA[11:8] <= DIGIT_MAX)
    else $error("seconds out of range");
  a_min_bcd_range: assert property (rd_of(A_HOUR) |=>
    !RDATA[7] && RDATA[6:4] <= 3'h5 && RDATA[3:0] <= DIGIT_MAX)
    else $error("minutes out of range");
  a_hour_bcd_range: assert property (rd_of(A_HOUR) |=>
    !RDATA[15] && RDATA[13:12] <= 2'h2 && RDATA[11:8] <= DIGIT_MAX)
    else $error("hours out of range");
  a_month_bcd_range: assert property (rd_of(A_MONTH) |=>
    RDATA[15:13] == 3'h0 && RDATA[12:8] != 5'h00 && RDATA[12:8] <= MONTH_MAX)
    else $error("month out of range");
  a_weekday_range: assert property (rd_of(A_YEAR) |=>
    RDATA[15:11] == 5'h00 && RDATA[10:8] <= WEEK_MAX)
    else $error("weekday out of range");
  a_pm_masked_24h: assert property (rd_of(A_HOUR) ##0 fmt24_reg |=> !RDATA[PM_BIT])
    else $error("pm visible in 24 hour mode");
  a_alarm_sets_flag: assert property (ALARM_EVENT ##1 rd_of(A_FLAG) |=> RDATA[F_ALARM])
    else $error("alarm flag not set");
  a_trim_sets_flag: assert property (TRIM_EVENT ##1 rd_of(A_FLAG) |=> RDATA[F_TRIM])
    else $error("trim flag not set");
  a_irq_off_masked: assert property (
    WR && ADDR == A_ENABLE && WDATA == 16'h0 ##1 !(WR && ADDR == A_ENABLE) |=> !IRQ)
    else $error("request with all enables off");
  c_alarm_irq: cover property (ALARM_EVENT ##2 IRQ);
  c_pm_read: cover property (rd_of(A_HOUR) ##1 RDATA[PM_BIT]);
  c_sw_running: cover property (rd_of(A_SW) ##1 RDATA[SW_GO_BIT]);
endmodule

bind rtc_calendar_counters rtc_calendar_counters_chk u_chk (
  .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .ALARM_EVENT(ALARM_EVENT), .TRIM_EVENT(TRIM_EVENT), .RDATA(RDATA), .IRQ(IRQ)
);

// ---- verification/test_rtc_calendar_counters.sv ----
// self-checking bench of the calendar counter block
// assumes small dividers: one second is 1024 clocks, stopwatch tick 6
`timescale 1ns/10ps
module test_rtc_calendar_counters
  import rtc_pkg::*;
;
  localparam int PD = 4;
  localparam int SD = 6;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic ALARM_EVENT = 1'b0;
  logic TRIM_EVENT = 1'b0;
  logic [15:0] RDATA;
  logic IRQ;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] d, a, b;
  // ----
  // case tables
  // ----
  logic [3:0] ra [6] = '{A_FLAG, A_SEC, A_HOUR, A_MONTH, A_YEAR, 4'h1};
  logic [15:0] rm [6] = '{16'hffff, 16'hff00, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] rv [6] = '{16'h0, 16'h0, 16'h1200, 16'h0101, 16'h0, 16'h0};
  logic [15:0] tc [6] = '{16'h0, 16'h0, 16'h0, 16'h0010, 16'h0010, 16'h0010};
  logic [15:0] th [6] = '{16'h5159, 16'h1159, 16'h5259, 16'h2359, 16'h6359, 16'h2359};
  logic [15:0] tm [6] = '{16'h1231, 16'h0228, 16'h0430, 16'h0228, 16'h0228, 16'h0430};
  logic [15:0] ty [6] = '{16'h0699, 16'h0201, 16'h0310, 16'h0001, 16'h0504, 16'h0110};
  logic [15:0] eh [6] = '{16'h1200, 16'h5200, 16'h4100, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] em [6] = '{16'h0101, 16'h0228, 16'h0430, 16'h0301, 16'h0229, 16'h0501};
  logic [15:0] ey [6] = '{16'h0000, 16'h0201, 16'h0310, 16'h0101, 16'h0604, 16'h0210};
  logic [15:0] ef [6] = '{16'h00f0, 16'h0070, 16'h0070, 16'h00f0, 16'h00f0, 16'h00f0};

  rtc_calendar_counters #(.PRESC_DIV(PD), .SW_DIV(SD)) u_dut (
    .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .ALARM_EVENT(ALARM_EVENT), .TRIM_EVENT(TRIM_EVENT), .RDATA(RDATA), .IRQ(IRQ)
  );

  initial begin
    forever #50 MCLK = ~MCLK;
  end
  // ----
  // shared tasks
  // ----
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] v);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= ad;
    WDATA <= v;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] v);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= ad;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // event pulse, then a flag read in the very next cycle
  task automatic pulse_rd(input logic al, input logic tr, output logic [15:0] v);
    @(posedge MCLK);
    ALARM_EVENT <= al;
    TRIM_EVENT <= tr;
    @(posedge MCLK);
    ALARM_EVENT <= 1'b0;
    TRIM_EVENT <= 1'b0;
    RD <= 1'b1;
    ADDR <= A_FLAG;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // polls busy; a read takes two clocks, busy lasts one prescaler step
  task automatic wait_sec();
    int n;
    n = 0;
    d = 16'h0;
    while (d[CTL_BUSY_BIT] !== 1'b1 && n < 600) begin
      rd(A_CTRL, d);
      n++;
    end
    chk({15'h0, d[CTL_BUSY_BIT]}, 16'h1);
    n = 0;
    while (d[CTL_BUSY_BIT] !== 1'b0 && n < 3) begin
      rd(A_CTRL, d);
      n++;
    end
    chk({15'h0, d[CTL_BUSY_BIT]}, 16'h0);
  endtask
  function automatic int bin(input logic [15:0] v);
    return v[15:12] * 10 + v[11:8];
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    repeat (6) @(posedge MCLK);
    SRST <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk(d & rm[i], rv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(A_CTRL, tc[i]);
      wait_sec();
      wr(A_FLAG, 16'hffff);
      wr(A_HOUR, th[i]);
      wr(A_SEC, 16'h5900);
      wr(A_MONTH, tm[i]);
      wr(A_YEAR, ty[i]);
      wait_sec();
      rd(A_HOUR, d);
      chk(d, eh[i]);
      rd(A_SEC, d);
      chk(d & 16'hff00, 16'h0000);
      rd(A_MONTH, d);
      chk(d, em[i]);
      rd(A_YEAR, d);
      chk(d, ey[i]);
      rd(A_FLAG, d);
      chk(d & 16'h00f0, ef[i]);
    end
    wr(A_CTRL, 16'h0000);
    rd(A_HOUR, d);
    chk(d, 16'h0000);
    // pm kept through a switch to 24h, dropped only by the next hour count
    wr(A_HOUR, 16'h5159);
    wr(A_SEC, 16'h5900);
    wr(A_CTRL, 16'h0010);
    wr(A_CTRL, 16'h0000);
    rd(A_HOUR, d);
    chk(d, 16'h5159);
    wr(A_CTRL, 16'h0010);
    wait_sec();
    wr(A_CTRL, 16'h0000);
    rd(A_HOUR, d);
    chk(d, 16'h1200);
    // taps after a clear; the divider phase is kept, so allow one step
    wr(A_CTRL, 16'h0002);
    rd(A_SEC, d);
    chk(d & 16'h00fe, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      repeat (200 + 200 * k) @(posedge MCLK);
      a = 16'h0;
      b = 16'h1;
      for (int n = 0; n < 4 && a !== b; n++) begin
        rd(A_SEC, a);
        rd(A_SEC, b);
      end
      chk(a & 16'h00e0, (k == 0) ? 16'h0020 : 16'h0080);
    end
    wr(A_ENABLE, 16'h0100);
    wr(A_FLAG, 16'hffff);
    pulse_rd(1'b1, 1'b0, d);
    chk(d & 16'hf100, 16'h0100);
    chk({15'h0, IRQ}, 16'h1);
    wr(A_FLAG, 16'h0000);
    rd(A_FLAG, d);
    chk(d & 16'h0100, 16'h0100);
    wr(A_FLAG, 16'h0100);
    pulse_rd(1'b0, 1'b1, d);
    chk(d & 16'hf100, 16'h8000);
    chk({15'h0, IRQ}, 16'h0);
    rd(A_ENABLE, d);
    chk(d, 16'h0100);
    wr(A_ENABLE, 16'h0000);
    wr(A_SW, 16'h0001);
    repeat (200) @(posedge MCLK);
    rd(A_SW, a);
    wr(A_SW, 16'h0000);
    // one late count may land up to a full tick period after the stop
    repeat (SD) @(posedge MCLK);
    rd(A_SW, b);
    repeat (60) @(posedge MCLK);
    rd(A_SW, d);
    chk(d, b);
    chk(16'(bin(b) - bin(a) <= 3), 16'h1);
    wr(A_SW, 16'h0001);
    repeat (60) @(posedge MCLK);
    rd(A_SW, d);
    chk(16'(bin(d) > bin(b) && bin(d) < bin(b) + 14), 16'h1);
    rd(A_FLAG, d);
    chk(d & 16'h7000, 16'h3000);
    give_verdict();
  end
  // ----
  // hang guard
  // ----
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end
endmodule
